// *** hdl/hc3_pkg.sv ***
// Shared constants of the 3D hand controller serial protocol block
package hc3_pkg;
	// Clock and link timing
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned BAUD            = 4800;
	localparam int unsigned BIT_CYCLES_DEF  = CLK_HZ / BAUD;
	localparam int unsigned UNIT_US         = 5000;
	localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * UNIT_US;
	localparam int unsigned KICK_US         = 25000;
	localparam int unsigned DUR_UNIT_US     = 40000;
	localparam int unsigned KICK_TICKS      = KICK_US / UNIT_US;
	localparam int unsigned DUR_TICKS       = DUR_UNIT_US / UNIT_US;

	// Host command characters
	localparam logic [7:0] CH_STAR    = 8'h2A;
	localparam logic [7:0] CH_BANG    = 8'h21;
	localparam logic [7:0] CH_S       = 8'h53;
	localparam logic [7:0] CH_T       = 8'h54;

	// Report headers and lengths
	localparam logic [2:0] HDR_STAT   = 3'h5;
	localparam logic [2:0] HDR_POS    = 3'h4;
	localparam logic [2:0] HDR_DYN    = 3'h6;
	localparam logic [3:0] LEN_STAT   = 4'hC;
	localparam logic [3:0] LEN_POS    = 4'h5;
	localparam logic [3:0] LEN_DYN    = 4'h4;

	// Register byte offsets and reset values
	localparam logic [3:0]  REG_VERSION  = 4'h0;
	localparam logic [3:0]  REG_AXIS_POS = 4'h4;
	localparam logic [3:0]  REG_AXIS_ROT = 4'h8;
	localparam logic [3:0]  REG_STATUS   = 4'hC;
	localparam logic [6:0]  VER_MAJOR_RST = 7'h01;
	localparam logic [6:0]  VER_MINOR_RST = 7'h00;
	localparam logic [23:0] AXIS_POS_RST  = 24'h626868;
	localparam logic [23:0] AXIS_ROT_RST  = 24'h626262;
endpackage : hc3_pkg

// *** hdl/hc3_uart.sv ***
// Byte serial receiver and transmitter, 8 data bits, 1 stop, no parity
`timescale 1ns/1ps
module hc3_uart #(
	parameter int unsigned BIT_CYCLES = hc3_pkg::BIT_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// Serial pins
	input  wire logic       rxd,
	output logic            txd,
	// Received bytes
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// Bytes to send
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	import hc3_pkg::*;

	localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
	// RULE1 bit time from link rate
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);

	logic          rx_meta_reg;
	logic          rx_sync_reg;
	logic          rx_busy_reg;
	logic [CW-1:0] rx_cnt_reg;
	logic [3:0]    rx_bit_reg;
	logic [8:0]    rx_shift_reg;
	logic          tx_busy_reg;
	logic [CW-1:0] tx_cnt_reg;
	logic [3:0]    tx_bit_reg;
	logic [9:0]    tx_shift_reg;

	////////////////////////////////////////////////////////////////
	// Pin synchroniser
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rxd;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Receiver: start bit checked at mid bit, then one sample per bit
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_busy_reg  <= 1'b0;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
			rx_data      <= 8'h00;
			rx_valid     <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rx_sync_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg  <= BIT_HALF;
					rx_bit_reg  <= 4'h0;
				end
			end else if (rx_cnt_reg != '0) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end else begin
				rx_cnt_reg   <= BIT_LAST;
				rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]};
				rx_bit_reg   <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0 && rx_sync_reg) begin
					// Glitch, not a start bit
					rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg == 4'h9) begin
					rx_busy_reg <= 1'b0;
					// Bytes with a broken stop bit are dropped
					if (rx_sync_reg) begin
						rx_data  <= rx_shift_reg[8:1];
						rx_valid <= 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmitter
	assign tx_ready = !tx_busy_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_busy_reg  <= 1'b0;
			tx_cnt_reg   <= '0;
			tx_bit_reg   <= 4'h0;
			tx_shift_reg <= 10'h3FF;
			txd          <= 1'b1;
		end else if (!tx_busy_reg) begin
			txd <= 1'b1;
			if (tx_valid) begin
				tx_busy_reg  <= 1'b1;
				tx_shift_reg <= {1'b1, tx_data, 1'b0};
				tx_cnt_reg   <= BIT_LAST;
				tx_bit_reg   <= 4'h0;
				txd          <= 1'b0;
			end
		end else if (tx_cnt_reg != '0) begin
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
		end else begin
			tx_cnt_reg   <= BIT_LAST;
			tx_bit_reg   <= tx_bit_reg + 4'h1;
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			txd          <= tx_shift_reg[1];
			if (tx_bit_reg == 4'h9) begin
				tx_busy_reg <= 1'b0;
				txd         <= 1'b1;
			end
		end
	end
endmodule : hc3_uart

// *** hdl/hc3_ctrl.sv ***
// Extended 3D mode protocol: command decode, report framing, tactile motor timing
//
// How it works
// RULE1 - Serial link runs at 4800 baud in extended 3D mode.
// RULE2 - Host changes baud only after mode entry characters fully left.
// RULE3 - Static status request in 3D mode returns a 12 byte report.
// RULE4 - Static byte 1 is 101 then zeros; later bytes bit 7 clear; 10-12 zero.
// RULE5 - Static bytes 2 and 3 carry major and minor version, seven bits.
// RULE6 - Bytes 4-9 describe six axes: absolute flag, self centring, zero bit.
// RULE7 - Low nibble of each axis descriptor gives precision bits, 0 to 15.
// RULE8 - Absolute axis sends displacement, unchanged while the axis is still.
// RULE9 - Relative axis sends change since last report, zero when still.
// RULE10 - Position report sent whenever buttons or coordinates changed since last.
// RULE11 - Position report is 5 bytes; header 100, buttons L M R in bits 2-0.
// RULE12 - X and Y are 8 bit values packed across bytes 2 to 4.
// RULE13 - Z, pitch, roll, yaw are 2 bit fields packed in bytes 4 and 5.
// RULE14 - All coordinate fields are two's complement.
// RULE15 - Tactile request: 21h 54h, on-time, off-time, duration; 5 ms units.
// RULE16 - Fifth tactile byte is total burst length in 40 ms steps.
// RULE17 - Burst: 25 ms kickstart plus on-time, then off/on until duration ends.
// RULE18 - No mouse compatible reports while in extended 3D mode.
// RULE19 - Leaving extended 3D mode only through reset.
// RULE20 - Power level tested at burst start; too high sends dynamic report.
// RULE21 - Motor held off while power level is flagged too high.
// RULE22 - Host treats bit 7 set as report start, type in bits 6-5.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module hc3_ctrl #(
	parameter int unsigned BIT_CYCLES  = hc3_pkg::BIT_CYCLES_DEF,
	parameter int unsigned TICK_CYCLES = hc3_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Serial pins
	input  wire logic        rxd,
	output logic             txd,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Sensor samples
	input  wire logic [7:0]  x_pos,
	input  wire logic [7:0]  y_pos,
	input  wire logic [1:0]  z_pos,
	input  wire logic [1:0]  pitch_axis,
	input  wire logic [1:0]  roll_axis,
	input  wire logic [1:0]  yaw_axis,
	input  wire logic [2:0]  buttons,
	// Power pins
	input  wire logic        ext_power_connected,
	input  wire logic        ext_power_too_high,
	// Status
	output logic             extended_3d_mode,
	output logic             mouse_report_enable,
	output logic             motor_on
);
	import hc3_pkg::*;

	typedef enum {P_IDLE, P_STAR, P_BANG, P_ON, P_OFF, P_DUR} hc3_parse_t;
	typedef enum {K_STAT, K_DYN, K_POS} hc3_kind_t;
	typedef enum {S_IDLE, S_SEND} hc3_seq_t;

	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        tx_ready;
	logic        tx_valid;
	logic [7:0]  tx_byte;
	hc3_parse_t  parse_reg;
	hc3_kind_t   kind_reg;
	hc3_seq_t    seq_reg;
	logic [3:0]  idx_reg;
	logic [7:0]  on_reg;
	logic [7:0]  off_reg;
	logic        stat_pend_reg;
	logic        dyn_pend_reg;
	logic        burst_go;
	logic [7:0]  dur_byte;
	logic [6:0]  ver_major_reg;
	logic [6:0]  ver_minor_reg;
	logic [23:0] axis_pos_reg;
	logic [23:0] axis_rot_reg;
	logic [1:0]  pwr_meta_reg;
	logic [1:0]  pwr_sync_reg;
	logic        too_high_reg;
	logic        burst_reg;
	logic        phase_on_reg;
	logic [8:0]  phase_left_reg;
	logic [10:0] burst_left_reg;
	logic [TW-1:0] tick_cnt_reg;
	logic        tick;
	logic [7:0]  last_x_reg;
	logic [7:0]  last_y_reg;
	logic [7:0]  last_rot_reg;
	logic [1:0]  last_z_reg;
	logic [2:0]  last_btn_reg;
	logic [36:0] snap_reg;
	logic        moved;
	logic [36:0] enc_next;

	hc3_uart #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_uart (
		.clock    (clock),
		.rstn     (rstn),
		.rxd      (rxd),
		.txd      (txd),
		.rx_data  (rx_data),
		.rx_valid (rx_valid),
		.tx_data  (tx_byte),
		.tx_valid (tx_valid),
		.tx_ready (tx_ready)
	);

	////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ver_major_reg <= VER_MAJOR_RST;
			ver_minor_reg <= VER_MINOR_RST;
			axis_pos_reg  <= AXIS_POS_RST;
			axis_rot_reg  <= AXIS_ROT_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_VERSION: begin
					ver_major_reg <= reg_wdata[6:0];
					ver_minor_reg <= reg_wdata[14:8];
				end
				REG_AXIS_POS: axis_pos_reg <= reg_wdata[23:0];
				REG_AXIS_ROT: axis_rot_reg <= reg_wdata[23:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_VERSION:  reg_rdata <= {17'h00000, ver_minor_reg, 1'b0, ver_major_reg};
				REG_AXIS_POS: reg_rdata <= {8'h00, axis_pos_reg};
				REG_AXIS_ROT: reg_rdata <= {8'h00, axis_rot_reg};
				REG_STATUS:   reg_rdata <= {27'h0000000, pwr_sync_reg[0], too_high_reg,
					burst_reg, motor_on, extended_3d_mode};
				default:      reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command decoder
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			parse_reg        <= P_IDLE;
			extended_3d_mode <= 1'b0;
			on_reg           <= 8'h00;
			off_reg          <= 8'h00;
		end else if (rx_valid) begin
			unique case (parse_reg)
				P_IDLE: begin
					if (!extended_3d_mode && rx_data == CH_STAR) begin
						parse_reg <= P_STAR;
					end else if (extended_3d_mode && rx_data == CH_BANG) begin
						parse_reg <= P_BANG;
					end
				end
				P_STAR: begin
					// RULE19 set only
					if (rx_data == CH_S) begin
						extended_3d_mode <= 1'b1;
					end
					parse_reg <= P_IDLE;
				end
				P_BANG: begin
					// RULE15 second byte
					parse_reg <= (rx_data == CH_T) ? P_ON : P_IDLE;
				end
				P_ON: begin
					on_reg    <= rx_data;
					parse_reg <= P_OFF;
				end
				P_OFF: begin
					off_reg   <= rx_data;
					parse_reg <= P_DUR;
				end
				P_DUR: parse_reg <= P_IDLE;
			endcase
		end
	end

	// RULE15 fifth byte starts burst
	assign burst_go = rx_valid && parse_reg == P_DUR;
	assign dur_byte = rx_data;

	// RULE18 mouse reports off
	assign mouse_report_enable = !extended_3d_mode;

	////////////////////////////////////////////////////////////////
	// Power level pins and over-level flag
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwr_meta_reg <= 2'b00;
			pwr_sync_reg <= 2'b00;
		end else begin
			pwr_meta_reg <= {ext_power_too_high, ext_power_connected};
			pwr_sync_reg <= pwr_meta_reg;
		end
	end

	// RULE20 tested at burst start
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			too_high_reg <= 1'b0;
		end else if (burst_go) begin
			too_high_reg <= pwr_sync_reg[1] && pwr_sync_reg[0];
		end else if (!pwr_sync_reg[0]) begin
			too_high_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Tactile burst timing in 5 ms ticks
	assign tick = burst_reg && tick_cnt_reg == '0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= '0;
		end else if (burst_go || tick) begin
			tick_cnt_reg <= TICK_LAST;
		end else if (burst_reg) begin
			tick_cnt_reg <= tick_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			burst_reg      <= 1'b0;
			phase_on_reg   <= 1'b0;
			phase_left_reg <= 9'h000;
			burst_left_reg <= 11'h000;
		end else if (burst_go) begin
			// RULE16 duration in 40 ms steps
			burst_left_reg <= 11'(dur_byte * DUR_TICKS);
			// RULE17 kickstart plus first on-time
			phase_left_reg <= 9'(on_reg + KICK_TICKS);
			phase_on_reg   <= 1'b1;
			// RULE21 no burst when over-level
			burst_reg      <= dur_byte != 8'h00 &&
				!(pwr_sync_reg[1] && pwr_sync_reg[0]);
		end else if (tick) begin
			burst_left_reg <= burst_left_reg - 11'h001;
			// RULE17 ends after total duration
			if (burst_left_reg <= 11'h001) begin
				burst_reg    <= 1'b0;
				phase_on_reg <= 1'b0;
			end else if (phase_left_reg <= 9'h001) begin
				// RULE17 alternate off and on
				if (phase_on_reg && off_reg != 8'h00) begin
					phase_on_reg   <= 1'b0;
					phase_left_reg <= {1'b0, off_reg};
				end else begin
					phase_on_reg   <= 1'b1;
					phase_left_reg <= {1'b0, on_reg};
				end
			end else begin
				phase_left_reg <= phase_left_reg - 9'h001;
			end
		end
	end

	// RULE21 motor held off
	assign motor_on = burst_reg && phase_on_reg && !too_high_reg;

	////////////////////////////////////////////////////////////////
	// Movement detection and coordinate encoding
	// RULE10 compare with last report
	assign moved = buttons != last_btn_reg || x_pos != last_x_reg ||
		y_pos != last_y_reg || z_pos != last_z_reg ||
		{pitch_axis, roll_axis, yaw_axis} != last_rot_reg[5:0];

	// Relative fields wrap rather than saturate; the host sees small steps only
	function automatic logic [7:0] axis_val(input logic abs_axis,
		input logic [7:0] cur, input logic [7:0] last);
		// RULE8 absolute tracks position
		// RULE9 relative sends change
		axis_val = abs_axis ? cur : 8'(cur - last);
	endfunction : axis_val

	always_comb begin
		enc_next[36:34] = buttons;
		enc_next[33:26] = axis_val(axis_pos_reg[6], x_pos, last_x_reg);
		enc_next[25:18] = axis_val(axis_pos_reg[14], y_pos, last_y_reg);
		enc_next[17:10] = axis_val(axis_pos_reg[22], {{6{z_pos[1]}}, z_pos},
			{{6{last_z_reg[1]}}, last_z_reg});
		enc_next[9:8]   = 2'(axis_val(axis_rot_reg[6], {{6{pitch_axis[1]}}, pitch_axis},
			{{6{last_rot_reg[5]}}, last_rot_reg[5:4]}));
		enc_next[7:6]   = 2'(axis_val(axis_rot_reg[14], {{6{roll_axis[1]}}, roll_axis},
			{{6{last_rot_reg[3]}}, last_rot_reg[3:2]}));
		enc_next[5:4]   = 2'(axis_val(axis_rot_reg[22], {{6{yaw_axis[1]}}, yaw_axis},
			{{6{last_rot_reg[1]}}, last_rot_reg[1:0]}));
		enc_next[3:0]   = 4'h0;
	end

	////////////////////////////////////////////////////////////////
	// Report sequencer: static first, then dynamic, then position
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stat_pend_reg <= 1'b0;
			dyn_pend_reg  <= 1'b0;
		end else begin
			// A new request in the launch cycle still counts
			if (rx_valid && parse_reg == P_BANG && rx_data == CH_S) begin
				stat_pend_reg <= 1'b1;
			end else if (seq_reg == S_IDLE) begin
				stat_pend_reg <= 1'b0;
			end
			// RULE20 dynamic report
			if (burst_go && pwr_sync_reg[1] && pwr_sync_reg[0]) begin
				dyn_pend_reg <= 1'b1;
			end else if (seq_reg == S_IDLE && !stat_pend_reg) begin
				dyn_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seq_reg      <= S_IDLE;
			kind_reg     <= K_POS;
			idx_reg      <= 4'h0;
			snap_reg     <= '0;
			last_x_reg   <= 8'h00;
			last_y_reg   <= 8'h00;
			last_z_reg   <= 2'b00;
			last_rot_reg <= 8'h00;
			last_btn_reg <= 3'b000;
		end else begin
			unique case (seq_reg)
				S_IDLE: begin
					idx_reg <= 4'h0;
					if (stat_pend_reg) begin
						// RULE3 send static
						kind_reg <= K_STAT;
						seq_reg  <= S_SEND;
					end else if (dyn_pend_reg) begin
						kind_reg <= K_DYN;
						seq_reg  <= S_SEND;
					end else if (extended_3d_mode && moved) begin
						// RULE10 send on change
						kind_reg     <= K_POS;
						seq_reg      <= S_SEND;
						snap_reg     <= enc_next;
						last_x_reg   <= x_pos;
						last_y_reg   <= y_pos;
						last_z_reg   <= z_pos;
						last_rot_reg <= {2'b00, pitch_axis, roll_axis, yaw_axis};
						last_btn_reg <= buttons;
					end
				end
				S_SEND: begin
					if (tx_ready) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == report_len(kind_reg) - 4'h1) begin
							seq_reg <= S_IDLE;
						end
					end
				end
			endcase
		end
	end

	function automatic logic [3:0] report_len(input hc3_kind_t k);
		unique case (k)
			K_STAT: report_len = LEN_STAT;
			K_DYN:  report_len = LEN_DYN;
			K_POS:  report_len = LEN_POS;
		endcase
	endfunction : report_len

	// RULE6 descriptor layout
	// RULE7 precision nibble
	function automatic logic [7:0] desc(input logic [7:0] d);
		desc = {1'b0, d[6:5], 1'b0, d[3:0]};
	endfunction : desc

	////////////////////////////////////////////////////////////////
	// Report byte selection
	assign tx_valid = seq_reg == S_SEND;

	always_comb begin
		tx_byte = 8'h00;
		unique case (kind_reg)
			K_STAT: begin
				// RULE4 header and zero tail
				unique case (idx_reg)
					4'h0: tx_byte = {HDR_STAT, 5'h00};
					// RULE5 version bytes
					4'h1: tx_byte = {1'b0, ver_major_reg};
					4'h2: tx_byte = {1'b0, ver_minor_reg};
					4'h3: tx_byte = desc(axis_pos_reg[7:0]);
					4'h4: tx_byte = desc(axis_pos_reg[15:8]);
					4'h5: tx_byte = desc(axis_pos_reg[23:16]);
					4'h6: tx_byte = desc(axis_rot_reg[7:0]);
					4'h7: tx_byte = desc(axis_rot_reg[15:8]);
					4'h8: tx_byte = desc(axis_rot_reg[23:16]);
					default: tx_byte = 8'h00;
				endcase
			end
			K_DYN: begin
				if (idx_reg == 4'h0) begin
					tx_byte = {HDR_DYN, 3'h0, too_high_reg, pwr_sync_reg[0]};
				end
			end
			K_POS: begin
				// RULE11 header and buttons
				// RULE12 X and Y packing
				// RULE13 small axis packing
				// RULE14 two's complement fields
				unique case (idx_reg)
					4'h0: tx_byte = {HDR_POS, 2'b00, snap_reg[36:34]};
					4'h1: tx_byte = {1'b0, snap_reg[33:27]};
					4'h2: tx_byte = {1'b0, snap_reg[26], snap_reg[25:20]};
					4'h3: tx_byte = {1'b0, snap_reg[19:18], snap_reg[11:10],
						snap_reg[9:8], snap_reg[7]};
					4'h4: tx_byte = {1'b0, snap_reg[6], snap_reg[5:4], 4'h0};
					default: tx_byte = 8'h00;
				endcase
			end
		endcase
	end
endmodule : hc3_ctrl

// *** sim/hc3_ctrl_asserts.sv ***
// Port level assertions of the protocol block
`timescale 1ns/1ps
module hc3_ctrl_asserts #(
	parameter int unsigned BIT_CYCLES  = 16,
	parameter int unsigned TICK_CYCLES = 20
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// Observed ports
	input wire logic        txd,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        extended_3d_mode,
	input wire logic        mouse_report_enable,
	input wire logic        motor_on
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	a_mouse_off_3d: assert property (mouse_report_enable == !extended_3d_mode)
		else $error("mouse reports enabled in 3D mode");
	a_mode_sticky: assert property ($past(extended_3d_mode) |-> extended_3d_mode)
		else $error("3D mode left without reset");
	a_status_mode:
		assert property ($past(reg_rd) && $past(reg_addr) == 4'hC
			|-> reg_rdata[0] == $past(extended_3d_mode))
		else $error("status mode bit wrong");
	a_version_seven:
		assert property ($past(reg_rd) && $past(reg_addr) == 4'h0
			|-> reg_rdata[7] == 1'b0 && reg_rdata[31:15] == 17'h0)
		else $error("version field wider than seven bits");
	a_flag_blocks_motor:
		assert property ($past(reg_rd) && $past(reg_addr) == 4'hC && reg_rdata[3]
			|-> !reg_rdata[1])
		else $error("motor on while power flagged too high");
	a_motor_in_3d: assert property (motor_on |-> extended_3d_mode)
		else $error("motor on outside 3D mode");
	// Needs TICK_CYCLES of at least 8
	a_on_phase_min: assert property ($rose(motor_on) |-> motor_on [*8])
		else $error("motor on phase too short");
	a_quiet_mouse: assert property (!extended_3d_mode |-> txd)
		else $error("serial output active in mouse mode");
	a_start_bit_len: assert property ($fell(txd) |-> !txd [*8])
		else $error("start bit too short");
endmodule : hc3_ctrl_asserts

bind hc3_ctrl hc3_ctrl_asserts #(.BIT_CYCLES(BIT_CYCLES), .TICK_CYCLES(TICK_CYCLES))
	u_hc3_ctrl_asserts (.clock, .rstn, .txd, .reg_addr, .reg_rd, .reg_rdata,
	.extended_3d_mode, .mouse_report_enable, .motor_on);

// *** sim/hc3_host.sv ***
// Host serial port model: sends command bytes, collects report bytes
`timescale 1ns/1ps
module hc3_host #(
	parameter int unsigned BIT_CYCLES = 16
) (
	// Clock
	input  wire logic clock,
	// Serial lines, named from the device side
	output logic      rxd,
	input  wire logic txd
);
	logic [7:0] rx_q[$];
	initial rxd = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CYCLES) @(posedge clock);
		end
	endtask : send_byte
	////////////////////////////////////////////////////////////////////////
	// frame received bytes
	always begin : rx_loop
		logic [7:0] d;
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clock);
			d[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge clock);
		rx_q.push_back(d);
	end
endmodule : hc3_host

// *** sim/tb.sv ***
// Self-checking bench of the protocol block
`timescale 1ns/1ps
module tb;
	localparam int unsigned BC = 16;
	localparam int unsigned TC = 20;
	logic        clock;
	logic        rstn;
	logic        rxd;
	logic        txd;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [7:0]  x_pos;
	logic [7:0]  y_pos;
	logic [1:0]  z_pos;
	logic [1:0]  pitch_axis;
	logic [1:0]  roll_axis;
	logic [1:0]  yaw_axis;
	logic [2:0]  buttons;
	logic        ext_power_connected;
	logic        ext_power_too_high;
	logic        extended_3d_mode;
	logic        mouse_report_enable;
	logic        motor_on;
	logic        last_m = 1'b0;
	int          run_n;
	int          runs[$];
	int          err_total;
	int          comparisons;

	hc3_ctrl #(.BIT_CYCLES(BC), .TICK_CYCLES(TC)) u_hc3_ctrl (
		.clock, .rstn, .rxd, .txd, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.x_pos, .y_pos, .z_pos, .pitch_axis, .roll_axis, .yaw_axis, .buttons,
		.ext_power_connected, .ext_power_too_high, .extended_3d_mode,
		.mouse_report_enable, .motor_on);
	hc3_host #(.BIT_CYCLES(BC)) host (.clock, .rxd, .txd);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Lengths of motor on and off runs, in clock cycles
	always @(posedge clock) begin
		run_n++;
		if (motor_on !== last_m) begin
			runs.push_back(run_n);
			run_n = 0;
			last_m = motor_on;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask : reg_write
	task automatic reg_check(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
		@(posedge clock);
	endtask : reg_check
	task automatic send(input logic [39:0] s, input int n);
		for (int i = 0; i < n; i++)
			host.send_byte(s[8 * (n - 1 - i) +: 8]);
	endtask : send
	task automatic flush();
		repeat (1000) @(posedge clock);
		host.rx_q.delete();
	endtask : flush
	task automatic expect_rep(input logic [95:0] e, input int n);
		int k;
		k = 0;
		while (host.rx_q.size() < n && k < 4000) begin
			@(posedge clock);
			k++;
		end
		if (k == 4000) begin
			err_total++;
			$display("[ERR] %0t report timeout", $time);
			stop_test();
		end
		for (int i = 0; i < n; i++)
			chk({24'h0, host.rx_q.pop_front()}, {24'h0, e[8 * (n - 1 - i) +: 8]});
	endtask : expect_rep
	function automatic logic [39:0] pos_rep(input logic [2:0] b, input logic [7:0] x, y,
		input logic [1:0] z, p, r, w);
		return {3'h4, 2'h0, b, 1'b0, x[7:1], 1'b0, x[0], y[7:2],
			1'b0, y[1:0], z, p, r[1], 1'b0, r[0], w, 4'h0};
	endfunction : pos_rep
	task automatic pos_step(input logic [2:0] b, input logic [7:0] x, input logic [7:0] xs);
		{buttons, x_pos, y_pos, z_pos, pitch_axis, roll_axis, yaw_axis} <=
			{b, x, 8'h3A, 2'h2, 2'h1, 2'h2, 2'h1};
		@(posedge clock);
		expect_rep({56'h0, pos_rep(b, xs, 8'h3A, 2'h2, 2'h1, 2'h2, 2'h1)}, 5);
	endtask : pos_step
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({31'h0, mouse_report_enable}, 32'h1);
		reg_check(4'h0, 32'hFFFFFFFF, 32'h00000001);
		reg_check(4'h4, 32'hFFFFFFFF, 32'h00626868);
		reg_check(4'h8, 32'hFFFFFFFF, 32'h00626262);
		reg_write(4'hC, 32'hFFFFFFFF);
		reg_check(4'hC, 32'hFFFFFFEF, 32'h0);
		reg_check(4'h2, 32'hFFFFFFFF, 32'h0);
	endtask : t_reset
	task automatic t_mode();
		send(40'h2153, 2);
		repeat (400) @(posedge clock);
		chk(host.rx_q.size(), 0);
		send(40'h2A53, 2);
		repeat (20) @(posedge clock);
		chk({31'h0, extended_3d_mode}, 32'h1);
		chk({31'h0, mouse_report_enable}, 32'h0);
	endtask : t_mode
	task automatic t_static();
		reg_write(4'h0, 32'h00003F7F);
		reg_write(4'h4, 32'h000F4168);
		send(40'h2153, 2);
		expect_rep(96'hA07F3F68410F626262000000, 12);
		reg_write(4'h4, 32'h00626868);
		flush();
	endtask : t_static
	task automatic t_position();
		pos_step(3'h5, 8'h85, 8'h85);
		repeat (1000) @(posedge clock);
		chk(host.rx_q.size(), 0);
		pos_step(3'h2, 8'h85, 8'h85);
		reg_write(4'h4, 32'h00626828);
		flush();
		pos_step(3'h2, 8'h90, 8'h0B);
		flush();
		pos_step(3'h7, 8'h90, 8'h00);
		flush();
	endtask : t_position
	task automatic t_tactile();
		runs.delete();
		send(40'h2154010101, 5);
		repeat (1000) @(posedge clock);
		chk(runs.size(), 4);
		if (runs.size() == 4) begin
			chk(runs[1], 6 * TC);
			chk(runs[2], TC);
			chk(runs[3], TC);
		end
	endtask : t_tactile
	task automatic t_power_high();
		ext_power_connected <= 1'b1;
		ext_power_too_high <= 1'b1;
		flush();
		runs.delete();
		send(40'h2154010101, 5);
		expect_rep(96'hC3000000, 4);
		repeat (300) @(posedge clock);
		chk(runs.size(), 0);
		reg_check(4'hC, 32'h0000001B, 32'h00000019);
	endtask : t_power_high
	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, x_pos, y_pos, z_pos, pitch_axis, roll_axis,
			yaw_axis, buttons, ext_power_connected, ext_power_too_high} = '0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_mode();
		t_static();
		t_position();
		t_tactile();
		t_power_high();
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		chk({31'h0, extended_3d_mode}, 32'h0);
		rstn <= 1'b1;
		stop_test();
	end
endmodule : tb
